/* src/fdc_pm_pkg.sv */
/*
 * Constants and carrier types for the floppy controller power manager.
 * Assumes a 10 MHz core clock and a host port decoded to three offset bits.
 */
package fdc_pm_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_KHZ = 10_000;
    localparam int IDLE_MS = 10;
    localparam int IDLE_CYCLES_DEF = IDLE_MS * CLK_KHZ;
    localparam int CNT_W = 20;

    // ************************************************************
    // Host port offsets
    // ************************************************************
    localparam logic [2:0] OFS_STATUS_A = 3'h0;
    localparam logic [2:0] OFS_STATUS_B = 3'h1;
    localparam logic [2:0] OFS_DRIVE_CTRL = 3'h2;
    localparam logic [2:0] OFS_RATE_MAIN = 3'h4;
    localparam logic [2:0] OFS_DATA_FIFO = 3'h5;
    localparam logic [2:0] OFS_DIN_CCTRL = 3'h7;

    // ************************************************************
    // Field positions and values
    // ************************************************************
    localparam int CFG0_POWER_BIT = 3;
    localparam int CFG7_FLOPPY_BIT = 7;
    localparam int DOC_MOTOR_LO = 4;
    localparam int DOC_RESET_N_BIT = 2;
    localparam int RSP_RESET_BIT = 7;
    localparam int RSP_PDOWN_BIT = 6;
    localparam logic [7:0] MSR_IDLE = 8'h80;
    localparam logic [7:0] DOC_RESET_VAL = 8'h00;
    localparam logic [3:0] MOTOR_NONE = 4'h0;

    // ************************************************************
    // Pin groups
    // ************************************************************
    typedef struct packed {
        logic [3:0] motor;
        logic [3:0] dsel;
        logic wdata;
        logic wgate;
    } float_pins_t;

    typedef struct packed {
        logic dir;
        logic step;
        logic head;
        logic density;
        logic [1:0] rate;
    } held_pins_t;

    typedef struct packed {
        logic track_zero;
        logic index_pulse;
        logic disk_change;
        logic second_drive;
    } drive_in_t;

endpackage : fdc_pm_pkg

/* src/floppy_auto_powerdown.sv */
/*
 * Floppy controller power manager: direct, rate-port, chip-level and auto
 * powerdown, wake-up decode of host accesses and drive pin gating.
 * Assumes the host strobes and drive inputs are asynchronous pins, and that
 * the controller core and configuration block share core_clk.
 */
// Summary of operation
// R1: Configuration zero power bit low forces direct powerdown, whatever auto mode does.
// R2: Auto powerdown is enabled only while configuration seven floppy bit is set.
// R3: Idle timer starts on enable and restarts on main status or data accesses.
// R4: Auto entry needs motors off, status 80H, no interrupt, head unloaded, timer lapsed.
// R5: Disabling auto mode cancels the timer and blocks auto entry.
// R6: Host waits 8us after auto wake, 8us or 4us after direct powerdown.
// R7: Rate port powerdown overrides auto powerdown; auto resumes after its wake.
// R8: Reset ending auto powerdown runs the normal reset sequence.
// R9: Register wake keeps all prior state, as if never powered down.
// R10: Wake on motor bit write, main status read, or data port access.
// R11: After wake the idle timer reloads with 10ms before powering down again.
// R12: Non-waking registers are served in powerdown, keeping written values.
// R13: Offsets 0,1,7 and reads of 2 never wake; 2 and rate writes wake only on motor or reset bits; 4 read, 5 wake.
// R14: Software reset through drive control or rate port wakes the controller.
// R15: Powerdown floats motor, drive select, write data and write gate pins.
// R16: Powerdown keeps direction, step, head, density and rate pins driven.
// R17: Powerdown keeps host pins working and holds interrupt and DMA request low.
// R18: Power-good low powers the controller down regardless of configuration.
// R19: The waking access itself completes normally with valid data.
`timescale 1ns/1ps
`default_nettype none

module floppy_auto_powerdown
    import fdc_pm_pkg::*;
#(
    parameter int IDLE_CYCLES = IDLE_CYCLES_DEF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Host port pins
    input wire logic io_rd_n,
    input wire logic io_wr_n,
    input wire logic [2:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rdata_oe,
    // Chip-level power input pin
    input wire logic power_good_input,
    // Configuration block
    input wire logic [7:0] config_register_zero,
    input wire logic [7:0] config_register_seven,
    // Controller core
    input wire logic [7:0] core_rdata,
    input wire logic [7:0] core_main_status,
    input wire logic core_irq,
    input wire logic core_dma_req,
    input wire logic core_head_unloaded,
    input wire float_pins_t core_float,
    input wire held_pins_t core_held,
    output logic core_soft_reset,
    output logic [7:0] core_drive_ctrl,
    output drive_in_t core_drive_in,
    // Power state
    output logic powered_down,
    output logic auto_asleep,
    // Drive pins
    input wire drive_in_t drive_in,
    output float_pins_t drive_float,
    output logic drive_float_oe,
    output held_pins_t drive_held,
    // Host request pins
    output logic floppy_irq_output,
    output logic floppy_dma_request
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    localparam int SYN_W = 1 + 1 + 3 + 8 + 1 + 4;
    logic [SYN_W-1:0] syn1_q;
    logic [SYN_W-1:0] syn2_q;
    logic rd_n_prev_q;
    logic wr_n_prev_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            syn1_q <= {SYN_W{1'b1}};
            syn2_q <= {SYN_W{1'b1}};
        end else begin
            syn1_q <= {io_rd_n, io_wr_n, io_addr, io_wdata,
                       power_good_input, drive_in};
            syn2_q <= syn1_q;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_n_prev_q <= 1'b1;
            wr_n_prev_q <= 1'b1;
        end else begin
            rd_n_prev_q <= syn2_q[SYN_W-1];
            wr_n_prev_q <= syn2_q[SYN_W-2];
        end
    end

    wire logic rd_n_s = syn2_q[SYN_W-1];
    wire logic wr_n_s = syn2_q[SYN_W-2];
    wire logic [2:0] addr_s = syn2_q[SYN_W-3 -: 3];
    wire logic [7:0] wdata_s = syn2_q[SYN_W-6 -: 8];
    wire logic pgood_s = syn2_q[4];
    wire drive_in_t drive_in_s = syn2_q[3:0];

    // ************************************************************
    // Access decode
    // ************************************************************
    wire logic rd_evt = rd_n_prev_q && !rd_n_s;
    wire logic wr_evt = wr_n_prev_q && !wr_n_s;
    wire logic hit_doc = addr_s == OFS_DRIVE_CTRL;
    wire logic hit_rm = addr_s == OFS_RATE_MAIN;
    wire logic hit_fifo = addr_s == OFS_DATA_FIFO;
    wire logic doc_wr = wr_evt && hit_doc;
    wire logic rsp_wr = wr_evt && hit_rm;
    wire logic msr_rd = rd_evt && hit_rm;
    wire logic fifo_acc = (rd_evt || wr_evt) && hit_fifo;
    wire logic motor_set = doc_wr
        && (wdata_s[DOC_MOTOR_LO +: 4] != MOTOR_NONE);
    wire logic doc_sw_reset = doc_wr && !wdata_s[DOC_RESET_N_BIT];
    wire logic rsp_sw_reset = rsp_wr && wdata_s[RSP_RESET_BIT];
    wire logic sw_reset = doc_sw_reset || rsp_sw_reset;
    // Only these accesses wake; offsets 0, 1, 7, reads of 2, and offset 2 or rate writes with no motor or reset bit do not.
    wire logic wake_acc = motor_set || msr_rd || fifo_acc || sw_reset; // [R10] [R13] [R14]
    wire logic timer_touch = msr_rd || fifo_acc; // [R3]

    // ************************************************************
    // Drive control shadow and host read data
    // ************************************************************
    logic [7:0] doc_q;
    logic [7:0] rdata_q;
    logic rdata_oe_q;
    logic soft_reset_q;

    wire logic [7:0] rdata_d = hit_doc ? doc_q : core_rdata; // [R12] [R19]

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            doc_q <= DOC_RESET_VAL;
            soft_reset_q <= 1'b0;
        end else begin
            if (doc_wr) begin
                doc_q <= wdata_s; // [R12]
            end
            soft_reset_q <= sw_reset; // [R8]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
            rdata_oe_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d; // [R12] [R19]
            rdata_oe_q <= !rd_n_s; // [R17]
        end
    end

    // ************************************************************
    // Idle timer
    // ************************************************************
    localparam logic [CNT_W-1:0] IDLE_LOAD = CNT_W'(IDLE_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    logic [CNT_W-1:0] idle_cnt_q;
    logic timer_run_q;
    logic auto_en_q;

    wire logic auto_en = config_register_seven[CFG7_FLOPPY_BIT]; // [R2]
    wire logic timer_lapsed = timer_run_q && (idle_cnt_q == CNT_ZERO);
    wire logic timer_reload = (auto_en && !auto_en_q) || timer_touch
        || wake_acc;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            auto_en_q <= 1'b0;
        end else begin
            auto_en_q <= auto_en;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            idle_cnt_q <= CNT_ZERO;
            timer_run_q <= 1'b0;
        end else begin
            if (!auto_en) begin
                timer_run_q <= 1'b0; // [R5]
                idle_cnt_q <= CNT_ZERO;
            end else if (timer_reload) begin
                timer_run_q <= 1'b1; // [R3] [R11]
                idle_cnt_q <= IDLE_LOAD;
            end else if (idle_cnt_q != CNT_ZERO) begin
                idle_cnt_q <= idle_cnt_q - CNT_W'(1);
            end
        end
    end

    // ************************************************************
    // Power state
    // ************************************************************
    logic auto_pd_q;
    logic rate_pd_q;
    logic pd_q;

    wire logic ctrl_idle = (doc_q[DOC_MOTOR_LO +: 4] == MOTOR_NONE)
        && (core_main_status == MSR_IDLE) && !core_irq
        && core_head_unloaded; // [R4]
    wire logic auto_enter = auto_en && ctrl_idle && timer_lapsed
        && !wake_acc; // [R4] [R5]
    wire logic direct_pd = !config_register_zero[CFG0_POWER_BIT]; // [R1]
    wire logic rate_pd_set = rsp_wr && wdata_s[RSP_PDOWN_BIT]
        && !rsp_sw_reset;
    wire logic pd_d = direct_pd || rate_pd_q || auto_pd_q
        || !pgood_s; // [R1] [R7] [R18]

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            auto_pd_q <= 1'b0;
        end else begin
            // A waking access clears the sleep flags and also reloads the idle timer.
            if (wake_acc || !auto_en) begin
                auto_pd_q <= 1'b0; // [R9] [R10] [R5]
            end else if (auto_enter) begin
                auto_pd_q <= 1'b1; // [R4]
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rate_pd_q <= 1'b0;
        end else begin
            if (rate_pd_set) begin
                rate_pd_q <= 1'b1; // [R7]
            end else if (wake_acc) begin
                rate_pd_q <= 1'b0; // [R7]
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pd_q <= 1'b0;
        end else begin
            pd_q <= pd_d;
        end
    end

    // ************************************************************
    // Pin gating
    // ************************************************************
    float_pins_t float_q;
    held_pins_t held_q;
    drive_in_t drive_in_q;
    logic float_oe_q;
    logic irq_q;
    logic drq_q;

    wire float_pins_t float_d = {doc_q[DOC_MOTOR_LO +: 4], core_float.dsel,
        core_float.wdata, core_float.wgate};

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            float_q <= '0;
            held_q <= '0;
            drive_in_q <= '0;
            float_oe_q <= 1'b0;
        end else begin
            float_q <= float_d;
            float_oe_q <= !pd_d; // [R15]
            held_q <= core_held; // [R16]
            drive_in_q <= drive_in_s; // [R15]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
            drq_q <= 1'b0;
        end else begin
            irq_q <= core_irq && !pd_d; // [R17]
            drq_q <= core_dma_req && !pd_d; // [R17]
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign io_rdata = rdata_q;
    assign io_rdata_oe = rdata_oe_q;
    assign core_soft_reset = soft_reset_q;
    assign core_drive_ctrl = doc_q;
    assign core_drive_in = drive_in_q;
    assign powered_down = pd_q;
    assign auto_asleep = auto_pd_q;
    assign drive_float = float_q;
    assign drive_float_oe = float_oe_q;
    assign drive_held = held_q;
    assign floppy_irq_output = irq_q;
    assign floppy_dma_request = drq_q;

endmodule : floppy_auto_powerdown

`default_nettype wire

/* testbench/core_model.sv */
/* Controller core stand-in with an idle and a busy state.
   Assumes the bench selects the state through busy. */
`timescale 1ns/1ps
`default_nettype none
module core_model
    import fdc_pm_pkg::*;
(
    // Control
    input wire logic busy,
    // Core side
    output logic [7:0] core_rdata,
    output logic [7:0] core_main_status,
    output logic core_irq,
    output logic core_dma_req,
    output logic core_head_unloaded,
    output float_pins_t core_float,
    output held_pins_t core_held,
    output drive_in_t drive_in
);
    assign core_rdata = 8'h5a;
    assign core_main_status = busy ? 8'h10 : MSR_IDLE;
    assign core_irq = busy;
    assign core_dma_req = busy;
    assign core_head_unloaded = !busy;
    assign core_float = 10'h2aa;
    assign core_held = 6'h2d;
    assign drive_in = 4'h5;
endmodule : core_model
`default_nettype wire

/* testbench/pd_properties.sv */
/* Port assertions for the floppy power manager.
   Bound into every floppy_auto_powerdown instance. */
`timescale 1ns/1ps
`default_nettype none
module pd_properties
    import fdc_pm_pkg::*;
(
    // Watched ports
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic io_rd_n,
    input wire logic io_wr_n,
    input wire logic [2:0] io_addr,
    input wire logic power_good_input,
    input wire logic [7:0] config_register_zero,
    input wire logic [7:0] config_register_seven,
    input wire logic [7:0] core_main_status,
    input wire logic core_irq,
    input wire logic core_head_unloaded,
    input wire held_pins_t core_held,
    input wire logic [7:0] core_drive_ctrl,
    input wire logic powered_down,
    input wire logic auto_asleep,
    input wire logic drive_float_oe,
    input wire held_pins_t drive_held,
    input wire logic floppy_irq_output,
    input wire logic floppy_dma_request
);
    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    sequence main_read_s;
        $fell(io_rd_n) && io_addr == OFS_RATE_MAIN;
    endsequence
    sequence data_access_s;
        ($fell(io_rd_n) || $fell(io_wr_n)) && io_addr == OFS_DATA_FIFO;
    endsequence
    sequence quiet_read_s;
        $fell(io_rd_n) && auto_asleep && io_addr inside {3'h0, 3'h1, 3'h7};
    endsequence
    irq_low_a: assert property (powered_down |-> !floppy_irq_output)
        else $error("interrupt raised in powerdown");
    drq_low_a: assert property (powered_down |-> !floppy_dma_request)
        else $error("dma request raised in powerdown");
    pins_float_a: assert property (powered_down |-> !drive_float_oe)
        else $error("drive pins driven in powerdown");
    held_driven_a: assert property (
        powered_down |-> drive_held == $past(core_held))
        else $error("held pins not driven in powerdown");
    direct_pd_a: assert property (
        !config_register_zero[CFG0_POWER_BIT] |-> ##[1:2] powered_down)
        else $error("direct powerdown not entered");
    pgood_pd_a: assert property (
        !power_good_input [*3] |-> ##[0:2] powered_down)
        else $error("power good low did not power down");
    auto_gate_a: assert property (
        !config_register_seven[CFG7_FLOPPY_BIT] [*3] |-> !auto_asleep)
        else $error("auto powerdown while disabled");
    entry_cond_a: assert property ($rose(auto_asleep) |->
        $past(core_main_status) == MSR_IDLE && !$past(core_irq) &&
        $past(core_head_unloaded) && ($past(core_drive_ctrl) & 8'hf0) == 8'h00)
        else $error("auto powerdown entered while busy");
    main_wake_a: assert property (main_read_s |-> ##[1:5] !auto_asleep)
        else $error("main status read did not wake");
    data_wake_a: assert property (data_access_s |-> ##[1:5] !auto_asleep)
        else $error("data port access did not wake");
    quiet_read_a: assert property (quiet_read_s |-> auto_asleep [*6])
        else $error("status read woke the controller");
endmodule : pd_properties
bind floppy_auto_powerdown pd_properties u_props (.*);
`default_nettype wire

/* testbench/tb_top.sv */
/* Self-checking bench for the floppy power manager.
   Assumes the checker is bound and the core model stands beside it. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fdc_pm_pkg::*;
    localparam int IDLE = 20;
    localparam logic [11:0] nw [6] = '{12'h000, 12'h100, 12'h700,
        12'ha0c, 12'hc02, 12'hf01};
    localparam logic [11:0] wk [6] = '{12'h400, 12'h500, 12'hd33,
        12'ha1c, 12'ha08, 12'hc80};
    logic core_clk = 1'h0, reset_n = 1'h0, io_rd_n = 1'h1, io_wr_n = 1'h1;
    logic [2:0] io_addr = 3'h0;
    logic [7:0] io_wdata = 8'h00, config_register_seven = 8'h00;
    logic [7:0] config_register_zero = 8'h08, rd_q;
    logic rd_oe;
    logic power_good_input = 1'h1, busy = 1'h0;
    logic [7:0] io_rdata, core_rdata, core_main_status, core_drive_ctrl;
    logic io_rdata_oe, core_irq, core_dma_req, core_head_unloaded;
    logic core_soft_reset, powered_down, auto_asleep, drive_float_oe;
    logic floppy_irq_output, floppy_dma_request;
    float_pins_t core_float, drive_float;
    held_pins_t core_held, drive_held;
    drive_in_t drive_in, core_drive_in;
    int n_errors = 0;
    int total_checks = 0;
    int n_rst = 0;
    floppy_auto_powerdown #(.IDLE_CYCLES(IDLE)) dut (.*);
    core_model partner (.*);
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) if (core_soft_reset === 1'h1) n_rst++;
    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic close_out();
        if (n_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [9:0] e, g);
        total_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic acc(input logic [11:0] op);
        io_addr = op[10:8];
        io_wdata = op[7:0];
        if (op[11]) io_wr_n = 1'h0;
        else io_rd_n = 1'h0;
        cyc(5);
        rd_q = io_rdata;
        rd_oe = io_rdata_oe;
        io_wr_n = 1'h1;
        io_rd_n = 1'h1;
        cyc(4);
    endtask : acc
    task automatic sleep();
        for (int i = 0; i < IDLE + 20 && auto_asleep !== 1'h1; i++) cyc(1);
        chk("auto_asleep", 1, auto_asleep);
        if (auto_asleep !== 1'h1) close_out();
    endtask : sleep
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_pins();
        chk("drive_ctrl", DOC_RESET_VAL, core_drive_ctrl);
        config_register_zero = 8'h00;
        busy = 1'h1;
        cyc(3);
        chk("powered_down", 1, powered_down);
        chk("float_oe", 0, drive_float_oe);
        chk("irq", 0, floppy_irq_output);
        chk("drq", 0, floppy_dma_request);
        chk("held", core_held, drive_held);
        chk("float pins", 10'h02a, drive_float);
        chk("drive_in", 4'h5, core_drive_in);
        config_register_zero = 8'h08;
        power_good_input = 1'h0;
        cyc(4);
        chk("powered_down", 1, powered_down);
        power_good_input = 1'h1;
        cyc(4);
        chk("powered_down", 0, powered_down);
        chk("irq", 1, floppy_irq_output);
        busy = 1'h0;
    endtask : t_pins
    task automatic t_auto();
        config_register_seven = 8'h80;
        cyc(IDLE - 2);
        chk("auto_asleep", 0, auto_asleep);
        sleep();
        cyc(1);
        chk("powered_down", 1, powered_down);
        chk("float_oe", 0, drive_float_oe);
        for (int i = 0; i < 6; i++) begin
            acc(nw[i]);
            chk("auto_asleep", 1, auto_asleep);
            chk("rdata_oe", i < 3, rd_oe);
            if (i < 3) chk("read data", 8'h5a, rd_q);
        end
        chk("drive_ctrl", 8'h0c, core_drive_ctrl);
    endtask : t_auto
    task automatic t_wake();
        for (int i = 0; i < 6; i++) begin
            sleep();
            acc(wk[i]);
            chk("auto_asleep", 0, auto_asleep);
            chk("powered_down", 0, powered_down);
            if (i < 2) chk("read data", 8'h5a, rd_q);
            if (i == 0) begin
                chk("drive_ctrl", 8'h0c, core_drive_ctrl);
                cyc(IDLE - 12);
                chk("auto_asleep", 0, auto_asleep);
            end
            acc(12'ha0c);
        end
        chk("soft reset", 2, 10'(n_rst));
    endtask : t_wake
    task automatic t_rate();
        sleep();
        acc(12'hc40);
        cyc(IDLE + 5);
        chk("powered_down", 1, powered_down);
        acc(12'h000);
        chk("powered_down", 1, powered_down);
        acc(12'h400);
        chk("powered_down", 0, powered_down);
        cyc(80);
        sleep();
    endtask : t_rate
    task automatic t_cancel();
        sleep();
        reset_n = 1'h0;
        cyc(2);
        chk("auto_asleep", 0, auto_asleep);
        chk("drive_ctrl", DOC_RESET_VAL, core_drive_ctrl);
        reset_n = 1'h1;
        cyc(3);
        config_register_seven = 8'h00;
        cyc(IDLE + 5);
        chk("auto_asleep", 0, auto_asleep);
        chk("powered_down", 0, powered_down);
        config_register_seven = 8'h80;
        busy = 1'h1;
        cyc(IDLE + 10);
        chk("auto_asleep", 0, auto_asleep);
        busy = 1'h0;
    endtask : t_cancel
    initial begin
        cyc(6);
        reset_n = 1'h1;
        cyc(3);
        t_pins();
        t_auto();
        t_wake();
        t_rate();
        t_cancel();
        close_out();
    end
    initial begin
        #5_000_000;
        chk("timeout", 0, 1);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
